/* spimsp_regs.svh */
// register map, field positions, reset values and timing counts of the spi port
`ifndef SPIMSP_REGS_SVH
`define SPIMSP_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses on apb)
// ----------------------------------------------------------------------------
`define SPIMSP_OFS_MODE     12'h000
`define SPIMSP_OFS_DATA     12'h004
`define SPIMSP_OFS_FMT      12'h008

// ----------------------------------------------------------------------------
// serial_mode_control fields
// ----------------------------------------------------------------------------
`define SPIMSP_MODE_MSB     7
`define SPIMSP_MODE_LSB     5
`define SPIMSP_EN_BIT       1
`define SPIMSP_MODE_RST     3'h7
`define SPIMSP_EN_RST       1'h0

// ----------------------------------------------------------------------------
// port_mode_select codes
// ----------------------------------------------------------------------------
`define SPIMSP_M_DIV4       3'h0
`define SPIMSP_M_DIV16      3'h1
`define SPIMSP_M_DIV64      3'h2
`define SPIMSP_M_SUB        3'h3
`define SPIMSP_M_TMR        3'h4
`define SPIMSP_M_SLAVE      3'h5

// ----------------------------------------------------------------------------
// spi_format_control fields
// ----------------------------------------------------------------------------
`define SPIMSP_POL_BIT      5
`define SPIMSP_EDGE_BIT     4
`define SPIMSP_MLS_BIT      3
`define SPIMSP_SELECT_PIN_ENABLE_BIT     2
`define SPIMSP_WRITE_COLLISION_FLAG_BIT     1
`define SPIMSP_TRF_BIT      0
`define SPIMSP_FMT_RST      1'h0
`define SPIMSP_DATA_RST     8'h00

// ----------------------------------------------------------------------------
// timing: pclk cycles per half serial clock, index of the last half period and of the last bit of a byte
// ----------------------------------------------------------------------------
`define SPIMSP_HALF_DIV4    6'h02
`define SPIMSP_HALF_DIV16   6'h08
`define SPIMSP_HALF_DIV64   6'h20
`define SPIMSP_LAST_HALF    5'h0F
`define SPIMSP_LAST_BIT     4'h7

`endif

/* spimsp_pkg.sv */
// types shared by the spi port and its testbench
package spimsp_pkg;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic scs_n;
  } spimsp_pins_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic scs_n_o;
    logic scs_n_oe;
  } spimsp_pins_out_t;

  typedef enum logic {
    SPIMSP_IDLE,
    SPIMSP_RUN
  } spimsp_state_t;

endpackage

/* spimsp_sync.sv */
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module spimsp_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[g] <= RST[g];
          sync_q[g] <= RST[g];
        end else begin
          meta_q[g] <= async_in[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule

/* spimsp_top.sv */
// spi master/slave port with apb register access
// Operation
// - master clock is pclk/4, /16, /64, low-speed clock, or half timer overflow
// - code 101 is slave; 110 two-wire and 111 reserved start nothing
// - enable low releases all pins and stops all activity
// - enable rising leaves every control register unchanged
// - polarity 0 idles clock high, 1 idles it low
// - edge select with polarity picks rising or falling capture edge
// - bit order 1 shifts msb first, 0 lsb first
// - select enable 0 floats select pin, 1 makes it the select
// - data write during a transfer is dropped and sets collision flag
// - done flag sets at byte end, holds until software writes zero
// - master data write starts full-duplex byte exchange at once
// - slave shifts data register out and in on master clocks
// - slave presents first bit per polarity and edge after select
// - port keeps running while the processor idles
// - all serial data passes through the one shared data register
// - unimplemented control bits read as zero
// - master starts transfers and makes the clock; slave only follows
`timescale 1ns/1ps
`include "spimsp_regs.svh"
module spimsp_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire spimsp_pkg::spimsp_pins_in_t  pins_i,
  input  wire logic                         low_speed_clock,
  input  wire logic                         timer_overflow,
  output spimsp_pkg::spimsp_pins_out_t      pins_o,
  output logic                              irq
);
  import spimsp_pkg::*;

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [2:0]    port_mode_select_q;
  logic          port_master_enable_q;
  logic          clock_idle_polarity_q;
  logic          capture_edge_select_q;
  logic          bit_order_select_q;
  logic          select_pin_enable_q;
  logic          write_collision_flag_q;
  logic          transfer_done_flag_q;
  logic          transfer_done_flag_d;
  logic [7:0]    serial_data_buffer_q;
  spimsp_state_t state_q;
  logic [4:0]    half_q;
  logic [3:0]    bit_q;
  logic [5:0]    div_q;
  logic          sck_q;
  logic          sdo_q;
  logic [3:0]    sync_q;
  logic          lsc_prev_q;
  logic          sck_prev_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;
  logic          irq_q;
  spimsp_pins_out_t pins_q;

  logic          lsc_s;
  logic          sck_s;
  logic          sdi_s;
  logic          scs_n_s;
  logic          is_master;
  logic          is_slave;
  logic          selected;
  logic          busy;
  logic          idle_lvl;
  logic          tick;
  logic [5:0]    half_lim;
  logic          ev;
  logic          lead;
  logic          capture;
  logic          launch;
  logic          done;
  logic          setup_acc;
  logic          acc;
  logic          wr_mode;
  logic          wr_data;
  logic          wr_fmt;
  logic          start;
  logic          out_bit;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // 0 mode, 1 data, 2 format, 3 unmapped; shared by read and write paths
  function automatic logic [1:0] reg_index(input logic [11:0] a);
    case (a)
      `SPIMSP_OFS_MODE: reg_index = 2'h0;
      `SPIMSP_OFS_DATA: reg_index = 2'h1;
      `SPIMSP_OFS_FMT:  reg_index = 2'h2;
      default:          reg_index = 2'h3;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic msb);
    shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  spimsp_sync #(
    .W   (4),
    .RST (4'h5)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({low_speed_clock, pins_i.sck, pins_i.sdi, pins_i.scs_n}),
    .sync_q   (sync_q)
  );

  assign lsc_s   = sync_q[3];
  assign sck_s   = sync_q[2];
  assign sdi_s   = sync_q[1];
  assign scs_n_s = sync_q[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsc_prev_q <= 1'h0;
      // idle-high levels, so the pull-up on sck gives no false edge after reset
      sck_prev_q <= 1'h1;
    end else begin
      lsc_prev_q <= lsc_s;
      sck_prev_q <= sck_s;
    end
  end

  // --------------------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // --------------------------------------------------------------------------
  assign setup_acc = psel & penable & ~pready_q;
  assign acc       = psel & penable & pready_q;
  assign wr_mode   = acc & pwrite & (reg_index(paddr) == 2'h0);
  assign wr_data   = acc & pwrite & (reg_index(paddr) == 2'h1);
  assign wr_fmt    = acc & pwrite & (reg_index(paddr) == 2'h2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_acc;
      pslverr_q <= setup_acc & (reg_index(paddr) == 2'h3);
      if (setup_acc && !pwrite) begin
        case (reg_index(paddr))
          2'h0:    prdata_q <= {24'h00_0000, port_mode_select_q, 3'h0,
                                port_master_enable_q, 1'h0};
          2'h1:    prdata_q <= {24'h00_0000, serial_data_buffer_q};
          2'h2:    prdata_q <= {24'h00_0000, 2'h0, clock_idle_polarity_q,
                                capture_edge_select_q, bit_order_select_q,
                                select_pin_enable_q, write_collision_flag_q,
                                transfer_done_flag_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // control registers; enable toggling never reinitialises them
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_mode_select_q   <= `SPIMSP_MODE_RST;
      port_master_enable_q <= `SPIMSP_EN_RST;
    end else if (wr_mode) begin
      port_mode_select_q   <= pwdata[`SPIMSP_MODE_MSB:`SPIMSP_MODE_LSB];
      port_master_enable_q <= pwdata[`SPIMSP_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_idle_polarity_q <= `SPIMSP_FMT_RST;
      capture_edge_select_q <= `SPIMSP_FMT_RST;
      bit_order_select_q    <= `SPIMSP_FMT_RST;
      select_pin_enable_q   <= `SPIMSP_FMT_RST;
    end else if (wr_fmt) begin
      clock_idle_polarity_q <= pwdata[`SPIMSP_POL_BIT];
      capture_edge_select_q <= pwdata[`SPIMSP_EDGE_BIT];
      bit_order_select_q    <= pwdata[`SPIMSP_MLS_BIT];
      select_pin_enable_q   <= pwdata[`SPIMSP_SELECT_PIN_ENABLE_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // mode decode and serial clock source
  // --------------------------------------------------------------------------
  // codes 110 and 111 fall in neither set, so nothing can start there
  assign is_master = port_master_enable_q & (port_mode_select_q <= `SPIMSP_M_TMR);
  assign is_slave  = port_master_enable_q & (port_mode_select_q == `SPIMSP_M_SLAVE);
  assign selected  = ~select_pin_enable_q | ~scs_n_s;
  assign busy      = (state_q == SPIMSP_RUN) | (is_slave & (bit_q != 4'h0));
  assign idle_lvl  = ~clock_idle_polarity_q;
  assign start     = wr_data & is_master & ~busy;
  assign out_bit   = bit_order_select_q ? serial_data_buffer_q[7]
                                        : serial_data_buffer_q[0];

  always_comb begin
    half_lim = `SPIMSP_HALF_DIV4;
    tick     = 1'h0;
    case (port_mode_select_q)
      `SPIMSP_M_DIV4:  half_lim = `SPIMSP_HALF_DIV4;
      `SPIMSP_M_DIV16: half_lim = `SPIMSP_HALF_DIV16;
      `SPIMSP_M_DIV64: half_lim = `SPIMSP_HALF_DIV64;
      default:         half_lim = `SPIMSP_HALF_DIV4;
    endcase
    case (port_mode_select_q)
      `SPIMSP_M_DIV4, `SPIMSP_M_DIV16, `SPIMSP_M_DIV64:
        tick = (div_q == half_lim - 6'h01);
      // each low-speed edge is half a period: sck runs at that clock's rate
      `SPIMSP_M_SUB: tick = (lsc_s != lsc_prev_q);
      // one toggle per overflow gives half the overflow rate
      `SPIMSP_M_TMR: tick = timer_overflow;
      default:       tick = 1'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 6'h00;
    end else if (state_q != SPIMSP_RUN || tick) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // --------------------------------------------------------------------------
  // edge classification; edge select 1 captures on the leading edge
  // --------------------------------------------------------------------------
  always_comb begin
    if (is_master) begin
      ev   = (state_q == SPIMSP_RUN) & tick;
      lead = (sck_q == idle_lvl);
    end else begin
      ev   = is_slave & selected & (sck_s != sck_prev_q);
      lead = (sck_prev_q == idle_lvl);
    end
    capture = ev & (lead == capture_edge_select_q);
    launch  = ev & ~capture;
    done    = is_master ? (ev & (half_q == `SPIMSP_LAST_HALF))
                        : (capture & is_slave & (bit_q == `SPIMSP_LAST_BIT));
  end

  // --------------------------------------------------------------------------
  // transfer sequencing (idle mode of the cpu does not gate any of it)
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SPIMSP_IDLE;
    end else begin
      case (state_q)
        SPIMSP_IDLE: if (start) state_q <= SPIMSP_RUN;
        SPIMSP_RUN:  if (!is_master || done) state_q <= SPIMSP_IDLE;
        default:     state_q <= SPIMSP_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 5'h00;
    end else if (start) begin
      half_q <= 5'h00;
    end else if (ev && is_master) begin
      half_q <= half_q + 5'h01;
    end
  end

  // slave bit count restarts whenever the select pin drops the port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 4'h0;
    end else if (!is_slave || !selected) begin
      bit_q <= 4'h0;
    end else if (capture) begin
      bit_q <= (bit_q == `SPIMSP_LAST_BIT) ? 4'h0 : bit_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'h1;
    end else if (state_q != SPIMSP_RUN) begin
      sck_q <= idle_lvl;
    end else if (tick) begin
      sck_q <= ~sck_q;
    end
  end

  // --------------------------------------------------------------------------
  // shared data register and output bit
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_data_buffer_q <= `SPIMSP_DATA_RST;
    end else if (wr_data && !busy) begin
      serial_data_buffer_q <= pwdata[7:0];
    end else if (capture) begin
      serial_data_buffer_q <= shift_in(serial_data_buffer_q, sdi_s,
                                       bit_order_select_q);
    end
  end

  // an idle port keeps its first bit on the line, ready before select falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_q <= 1'h0;
    end else if (start) begin
      sdo_q <= bit_order_select_q ? pwdata[7] : pwdata[0];
    end else if (launch || !busy) begin
      sdo_q <= out_bit;
    end
  end

  // --------------------------------------------------------------------------
  // status flags: hardware set wins over a software write
  // --------------------------------------------------------------------------
  assign transfer_done_flag_d = done |
    (wr_fmt ? pwdata[`SPIMSP_TRF_BIT] : transfer_done_flag_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_collision_flag_q <= `SPIMSP_FMT_RST;
      transfer_done_flag_q   <= `SPIMSP_FMT_RST;
      irq_q                  <= 1'h0;
    end else begin
      write_collision_flag_q <= (wr_data & busy) |
        (wr_fmt ? pwdata[`SPIMSP_WRITE_COLLISION_FLAG_BIT] : write_collision_flag_q);
      transfer_done_flag_q   <= transfer_done_flag_d;
      irq_q                  <= transfer_done_flag_d & ~transfer_done_flag_q;
    end
  end

  // --------------------------------------------------------------------------
  // pin drivers; disabled port lets all pins go back to plain i/o
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= '0;
    end else begin
      pins_q.sck_o    <= sck_q;
      pins_q.sck_oe   <= is_master;
      pins_q.sdo_o    <= sdo_q;
      pins_q.sdo_oe   <= is_master | (is_slave & selected);
      pins_q.scs_n_o  <= (state_q != SPIMSP_RUN);
      pins_q.scs_n_oe <= is_master & select_pin_enable_q;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign pins_o  = pins_q;
  assign irq     = irq_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start_div4;
    start && port_mode_select_q == `SPIMSP_M_DIV4;
  endsequence

  sequence s_byte_done;
    ##[22:26] transfer_done_flag_q;
  endsequence

  property p_collision;
    wr_data && busy && !capture |=> write_collision_flag_q && $stable(serial_data_buffer_q);
  endproperty
  a_collision: assert property (p_collision) else $error("collision not flagged");

  property p_done_sticky;
    transfer_done_flag_q && !wr_fmt |=> transfer_done_flag_q;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

  property p_irq_edge;
    $rose(transfer_done_flag_q) |-> irq;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("no irq on done");

  property p_idle_level;
    is_master && state_q == SPIMSP_IDLE ##1 is_master |=> pins_o.sck_o == idle_lvl;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("bad idle clock");

  property p_disabled;
    !port_master_enable_q |=> !pins_o.sck_oe && !pins_o.sdo_oe && !pins_o.scs_n_oe;
  endproperty
  a_disabled: assert property (p_disabled) else $error("pin driven while off");

  property p_start;
    start |=> state_q == SPIMSP_RUN;
  endproperty
  a_start: assert property (p_start) else $error("write did not start");

  property p_div4_len;
    s_start_div4 ##1 (is_master && !wr_fmt)[*8] |-> s_byte_done;
  endproperty
  a_div4_len: assert property (p_div4_len) else $error("byte length wrong");

  property p_select_float;
    !select_pin_enable_q |=> !pins_o.scs_n_oe;
  endproperty
  a_select_float: assert property (p_select_float) else $error("select driven");

  property p_reserved;
    port_master_enable_q && port_mode_select_q[2:1] == 2'h3 |-> !start;
  endproperty
  a_reserved: assert property (p_reserved) else $error("start in reserved mode");

  property p_order_first;
    start && capture_edge_select_q |=> sdo_q == (bit_order_select_q ? $past(pwdata[7])
                                                                     : $past(pwdata[0]));
  endproperty
  a_order_first: assert property (p_order_first) else $error("first bit wrong");
endmodule

/* spimsp_slave_model.sv */
// behavioural spi slave standing on the far side of the port
`timescale 1ns/1ps
module spimsp_slave_model (
  input  wire logic       sck,
  input  wire logic       scs_n,
  input  wire logic       sdo,
  input  wire logic       msb_first,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            sdi
);
  int   cnt  = 0;
  logic last = 1'b0;
  logic bit_v;

  // capture on the falling edge: idle-high clock with edge select 1
  always @(negedge sck or posedge scs_n) begin
    if (scs_n) begin
      cnt <= 0;
    end else begin
      rx_byte <= msb_first ? {rx_byte[6:0], sdo} : {sdo, rx_byte[7:1]};
      cnt     <= cnt + 1;
    end
  end

  // released line keeps no value, so flip it on every deselect
  always @(posedge scs_n) begin
    last <= ~last;
  end

  assign bit_v = msb_first ? tx_byte[3'h7 - cnt[2:0]] : tx_byte[cnt[2:0]];
  assign sdi   = scs_n ? ~last : bit_v;
endmodule

/* spi_master_slave_port_test.sv */
// self-checking bench: apb register checks, master byte transfers and a slave byte
`timescale 1ns/1ps
`include "spimsp_regs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module spi_master_slave_port_test;
  import spimsp_pkg::*;
  logic             pclk    = 1'b0;
  logic             presetn = 1'b0;
  logic             psel    = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite  = 1'b0;
  logic [11:0]      paddr   = '0;
  logic [31:0]      pwdata  = '0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  spimsp_pins_in_t  pins_i;
  spimsp_pins_out_t pins_o;
  logic             irq;
  logic             sck_w;
  logic             scs_w;
  logic             sdi_w;
  logic             msb_f   = 1'b1;
  logic [7:0]       ptx     = 8'h3C;
  logic [7:0]       prx;
  logic [31:0]      rd;
  logic             er;
  logic             sck_p   = 1'b0;
  logic             sck_m   = 1'b1;
  logic             scs_m   = 1'b1;
  logic             sdi_m   = 1'b0;
  logic [7:0]       mi;
  int               i0s = 0;
  int               err_count = 0;
  int               total_checks = 0;
  int               irq_n = 0;
  int               tgl_n = 0;
  int               gap = 0;
  int               gcnt = 0;

  // bench drives clock and select, idle high, whenever the port leaves them free
  assign sck_w  = pins_o.sck_oe ? pins_o.sck_o : sck_m;
  assign scs_w  = pins_o.scs_n_oe ? pins_o.scs_n_o : scs_m;
  assign pins_i = '{sck: sck_w, sdi: scs_m ? sdi_w : sdi_m, scs_n: scs_w};

  spimsp_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_i(pins_i), .low_speed_clock(1'b0), .timer_overflow(1'b0), .pins_o(pins_o), .irq(irq)
  );

  spimsp_slave_model u_slave (
    .sck(sck_w), .scs_n(scs_w), .sdo(pins_o.sdo_o), .msb_first(msb_f),
    .tx_byte(ptx), .rx_byte(prx), .sdi(sdi_w)
  );

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // edge counter and half-period meter on the driven clock
  always @(posedge pclk) begin
    irq_n <= irq_n + int'(irq === 1'b1);
    sck_p <= pins_o.sck_o;
    if (pins_o.sck_o !== sck_p) begin
      tgl_n <= tgl_n + 1;
      gap   <= gcnt;
      gcnt  <= 1;
    end else begin
      gcnt <= gcnt + 1;
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic xfer(input logic [2:0] m, input int half, input logic bit_order_select, input logic [7:0] d);
    int         t0;
    int         i0;
    int         n;
    logic [7:0] f;
    f     = {4'h1, bit_order_select, 3'h4};
    msb_f = bit_order_select;
    apb(1'b1, `SPIMSP_OFS_FMT, {24'h0, f});
    apb(1'b1, `SPIMSP_OFS_MODE, {24'h0, m, 5'h02});
    apb(1'b0, `SPIMSP_OFS_FMT, 32'h0);
    `CHK(rd, {24'h0, f})
    `CHK(pins_o.sck_o, 1'b1)
    t0 = tgl_n;
    i0 = irq_n;
    apb(1'b1, `SPIMSP_OFS_DATA, {24'h0, d});
    apb(1'b1, `SPIMSP_OFS_DATA, {24'h0, ~d});
    n = 0;
    do begin
      apb(1'b0, `SPIMSP_OFS_FMT, 32'h0);
      n++;
    end while (rd[`SPIMSP_TRF_BIT] !== 1'b1 && n < 400);
    if (n >= 400) begin
      err_count++;
      complete_run();
    end
    `CHK(rd, {24'h0, f | 8'h03})
    `CHK(prx, d)
    `CHK(tgl_n - t0, 16)
    `CHK(gap, half)
    `CHK(irq_n - i0, 1)
    apb(1'b0, `SPIMSP_OFS_DATA, 32'h0);
    `CHK(rd, {24'h0, ptx})
    apb(1'b1, `SPIMSP_OFS_FMT, {24'h0, f});
    apb(1'b0, `SPIMSP_OFS_FMT, 32'h0);
    `CHK(rd, {24'h0, f})
    apb(1'b1, `SPIMSP_OFS_MODE, 32'h0);
    repeat (4) @(posedge pclk);
    `CHK({pins_o.sck_oe, pins_o.sdo_oe, pins_o.scs_n_oe}, 3'h0)
  endtask

  // bench as master: select first, data on rising, port captures on falling
  task automatic slv(input logic [7:0] mo, output logic [7:0] so);
    scs_m <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi_m <= mo[i];
      repeat (8) @(posedge pclk);
      sck_m <= 1'b0;
      so[i] = pins_o.sdo_o;
      repeat (8) @(posedge pclk);
      sck_m <= 1'b1;
    end
    repeat (8) @(posedge pclk);
    scs_m <= 1'b1;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SPIMSP_OFS_MODE, 32'h0);
    `CHK(rd, 32'hE0)
    `CHK({pins_o.sck_oe, pins_o.sdo_oe, pins_o.scs_n_oe}, 3'h0)
    apb(1'b0, `SPIMSP_OFS_FMT, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, `SPIMSP_OFS_DATA, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, `SPIMSP_OFS_MODE, 32'hFF);
    apb(1'b0, `SPIMSP_OFS_MODE, 32'h0);
    `CHK(rd, 32'hE2)
    // reserved mode with enable set must not start a clock
    apb(1'b1, `SPIMSP_OFS_DATA, 32'h5A);
    repeat (40) @(posedge pclk);
    `CHK({pins_o.sck_oe, pins_o.sdo_oe, pins_o.scs_n_oe}, 3'h0)
    apb(1'b0, `SPIMSP_OFS_FMT, 32'h0);
    `CHK(rd[`SPIMSP_TRF_BIT], 1'b0)
    xfer(`SPIMSP_M_DIV16, `SPIMSP_HALF_DIV16, 1'b1, 8'hA5);
    xfer(`SPIMSP_M_DIV64, `SPIMSP_HALF_DIV64, 1'b0, 8'h96);
    apb(1'b1, `SPIMSP_OFS_FMT, 32'h1C);
    apb(1'b1, `SPIMSP_OFS_MODE, {24'h0, `SPIMSP_M_SLAVE, 5'h02});
    apb(1'b1, `SPIMSP_OFS_DATA, 32'hC3);
    i0s = irq_n;
    slv(8'h69, mi);
    `CHK(mi, 8'hC3)
    `CHK(irq_n - i0s, 1)
    apb(1'b0, `SPIMSP_OFS_DATA, 32'h0);
    `CHK(rd, 32'h69)
    apb(1'b0, `SPIMSP_OFS_FMT, 32'h0);
    `CHK(rd, 32'h1D)
    complete_run();
  end
endmodule
